// File: design/pin_sampler.sv
`timescale 1ns/1ps

module pin_sampler (
	input  wire logic                                  ref_clk,
	input  wire logic                                  sys_rst,
	input  wire logic [dac_loader_pkg::PIN_COUNT-1:0] pin_in,
	output logic      [dac_loader_pkg::PIN_COUNT-1:0] level,
	output logic      [dac_loader_pkg::PIN_COUNT-1:0] rise,
	output logic      [dac_loader_pkg::PIN_COUNT-1:0] fall
);

	typedef struct packed {
		logic [dac_loader_pkg::PIN_COUNT-1:0] meta;
		logic [dac_loader_pkg::PIN_COUNT-1:0] stable;
		logic [dac_loader_pkg::PIN_COUNT-1:0] prev;
	} sampler_s;

	sampler_s st_ff;
	sampler_s nxt_st;

	// The first stage is read only by the second stage; edges come from later stages.
	always_comb begin
		nxt_st        = st_ff;
		nxt_st.meta   = pin_in;
		nxt_st.stable = st_ff.meta;
		nxt_st.prev   = st_ff.stable;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	genvar i;
	generate
		for (i = 0; i < dac_loader_pkg::PIN_COUNT; i++) begin : g_lane
			assign level[i] = st_ff.stable[i];
			assign rise[i]  = st_ff.stable[i] & ~st_ff.prev[i];
			assign fall[i]  = ~st_ff.stable[i] & st_ff.prev[i];
		end
	endgenerate

endmodule

// File: design/serial_dac_word_loader.sv
`timescale 1ns/1ps

// Function
// - After reset, data is captured on the falling shift-clock edge until changed.
// - Command bits in the serial word can switch capture to the rising edge.
// - A 16-bit shift register takes one serial input bit per active edge.
// - Frame line falling opens the input path and enables the shift register.
// - Active edges are counted and, for a load command, the data field is latched on the sixteenth.
// - Serial output changes on the shift-clock edge opposite to capture.
// - The readback command loads the DAC register for shifting out.
// - Serial output carries shifted data so a following device can chain.
module serial_dac_word_loader (
	input  wire logic                                  ref_clk,
	input  wire logic                                  sys_rst,
	input  wire logic                                  sclk_pin,
	input  wire logic                                  sync_n,
	input  wire logic                                  serial_in,
	output logic                                       serial_out,
	output logic      [dac_loader_pkg::DATA_BITS-1:0] dac_code,
	output logic                                       dac_update,
	output logic                                       capture_rising,
	output logic                                       frame_active
);

	typedef struct packed {
		dac_loader_pkg::link_state_e               state;
		logic [dac_loader_pkg::WORD_BITS-1:0]      shift;
		logic [dac_loader_pkg::CNT_BITS-1:0]       count;
		logic [dac_loader_pkg::DATA_BITS-1:0]      dac;
		logic                                      cap_rise;
		logic                                      out_bit;
		logic                                      update;
	} loader_s;

	loader_s st_ff;
	loader_s nxt_st;

	logic [dac_loader_pkg::PIN_COUNT-1:0] pin_vec;
	logic [dac_loader_pkg::PIN_COUNT-1:0] pin_level;
	logic [dac_loader_pkg::PIN_COUNT-1:0] pin_rise;
	logic [dac_loader_pkg::PIN_COUNT-1:0] pin_fall;

	logic                                  frame_start;
	logic                                  frame_end;
	logic                                  cap_edge;
	logic                                  out_edge;
	logic                                  data_bit;
	logic [dac_loader_pkg::WORD_BITS-1:0]  new_word;
	logic [dac_loader_pkg::CMD_BITS-1:0]   new_cmd;

	// All three pins pass the same three stages, so data keeps its alignment to the clock edges.
	assign pin_vec[dac_loader_pkg::PIN_SCLK] = sclk_pin;
	assign pin_vec[dac_loader_pkg::PIN_SYNC] = sync_n;
	assign pin_vec[dac_loader_pkg::PIN_DATA] = serial_in;

	pin_sampler u_pins (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.pin_in  (pin_vec),
		.level   (pin_level),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	assign frame_start = pin_fall[dac_loader_pkg::PIN_SYNC];
	assign frame_end   = pin_rise[dac_loader_pkg::PIN_SYNC];
	assign data_bit    = pin_level[dac_loader_pkg::PIN_DATA];

	// The capture edge follows the stored selection; the output edge is always the other one.
	assign cap_edge = st_ff.cap_rise ? pin_rise[dac_loader_pkg::PIN_SCLK]
	                                 : pin_fall[dac_loader_pkg::PIN_SCLK];
	assign out_edge = st_ff.cap_rise ? pin_fall[dac_loader_pkg::PIN_SCLK]
	                                 : pin_rise[dac_loader_pkg::PIN_SCLK];

	assign new_word = {st_ff.shift[dac_loader_pkg::WORD_BITS-2:0], data_bit};
	assign new_cmd  = new_word[dac_loader_pkg::CMD_MSB:dac_loader_pkg::CMD_LSB];

	always_comb begin
		nxt_st        = st_ff;
		nxt_st.update = 1'b0;
		unique case (st_ff.state)
			dac_loader_pkg::ST_IDLE: begin
				if (frame_start) begin
					nxt_st.state   = dac_loader_pkg::ST_SHIFT;
					nxt_st.count   = dac_loader_pkg::CNT_RST;
					nxt_st.out_bit = st_ff.shift[dac_loader_pkg::WORD_BITS-1];
				end
			end
			dac_loader_pkg::ST_SHIFT: begin
				if (frame_end) begin
					nxt_st.state = dac_loader_pkg::ST_IDLE;
				end else if (cap_edge) begin
					nxt_st.shift = new_word;
					nxt_st.count = st_ff.count + 5'h01;
					if (st_ff.count == dac_loader_pkg::LAST_EDGE) begin
						nxt_st.state = dac_loader_pkg::ST_HOLD;
						case (new_cmd)
							dac_loader_pkg::CMD_LOAD: begin
								nxt_st.dac    = new_word[dac_loader_pkg::DATA_BITS-1:0];
								nxt_st.update = 1'b1;
							end
							dac_loader_pkg::CMD_READBACK: begin
								nxt_st.shift = {dac_loader_pkg::CMD_NOP, st_ff.dac};
							end
							dac_loader_pkg::CMD_EDGE_RISE: begin
								nxt_st.cap_rise = 1'b1;
							end
							dac_loader_pkg::CMD_EDGE_FALL: begin
								nxt_st.cap_rise = 1'b0;
							end
							default: begin
								nxt_st.update = 1'b0;
							end
						endcase
					end
				end else if (out_edge) begin
					nxt_st.out_bit = st_ff.shift[dac_loader_pkg::WORD_BITS-1];
				end
			end
			dac_loader_pkg::ST_HOLD: begin
				// Extra bits keep passing through for the next device, but nothing is latched again.
				if (frame_end) begin
					nxt_st.state = dac_loader_pkg::ST_IDLE;
				end else if (cap_edge) begin
					nxt_st.shift = new_word;
				end else if (out_edge) begin
					nxt_st.out_bit = st_ff.shift[dac_loader_pkg::WORD_BITS-1];
				end
			end
			default: begin
				nxt_st.state = dac_loader_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_ff.state    <= dac_loader_pkg::ST_IDLE;
			st_ff.shift    <= dac_loader_pkg::SHIFT_RST;
			st_ff.count    <= dac_loader_pkg::CNT_RST;
			st_ff.dac      <= dac_loader_pkg::DAC_RST;
			st_ff.cap_rise <= dac_loader_pkg::EDGE_RST;
			st_ff.out_bit  <= 1'b0;
			st_ff.update   <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign serial_out     = st_ff.out_bit;
	assign dac_code       = st_ff.dac;
	assign dac_update     = st_ff.update;
	assign capture_rising = st_ff.cap_rise;
	assign frame_active   = (st_ff.state != dac_loader_pkg::ST_IDLE);

endmodule

// File: include/dac_loader_pkg.sv
package dac_loader_pkg;

	// Serial word layout.
	localparam int unsigned WORD_BITS = 16;
	localparam int unsigned CNT_BITS  = 5;
	localparam int unsigned CMD_MSB   = 15;
	localparam int unsigned CMD_LSB   = 12;
	localparam int unsigned CMD_BITS  = 4;
	localparam int unsigned DATA_BITS = 12;
	localparam logic [CNT_BITS-1:0] LAST_EDGE = 5'h0F;

	// Pin sampler lanes.
	localparam int unsigned PIN_COUNT = 3;
	localparam int unsigned PIN_SCLK  = 0;
	localparam int unsigned PIN_SYNC  = 1;
	localparam int unsigned PIN_DATA  = 2;

	// Command field codes.
	localparam logic [CMD_BITS-1:0] CMD_NOP       = 4'h0;
	localparam logic [CMD_BITS-1:0] CMD_LOAD      = 4'h1;
	localparam logic [CMD_BITS-1:0] CMD_READBACK  = 4'h2;
	localparam logic [CMD_BITS-1:0] CMD_EDGE_FALL = 4'hB;
	localparam logic [CMD_BITS-1:0] CMD_EDGE_RISE = 4'hC;

	// Reset values.
	localparam logic [WORD_BITS-1:0] SHIFT_RST = 16'h0000;
	localparam logic [DATA_BITS-1:0] DAC_RST   = 12'h000;
	localparam logic [CNT_BITS-1:0]  CNT_RST   = 5'h00;
	localparam logic                 EDGE_RST  = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_HOLD  = 2'b10
	} link_state_e;

endpackage

// File: testbench/serial_dac_word_loader_checker.sv
`timescale 1ns/1ps
module serial_dac_word_loader_checker (
	input wire logic                                  ref_clk,
	input wire logic                                  sys_rst,
	input wire logic                                  sclk_pin,
	input wire logic                                  sync_n,
	input wire logic                                  serial_in,
	input wire logic                                  serial_out,
	input wire logic [dac_loader_pkg::DATA_BITS-1:0] dac_code,
	input wire logic                                  dac_update,
	input wire logic                                  capture_rising,
	input wire logic                                  frame_active
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// The pin samplers add up to five cycles between a pin edge and its effect.
	sequence opens_s; ##[2:5] frame_active; endsequence
	sequence closes_s; ##[2:5] !frame_active; endsequence
	AST_RST: assert property (disable iff (1'b0) sys_rst |=> dac_code == 12'h000 && !capture_rising && !dac_update)
		else $error("outputs not cleared by reset");
	AST_START: assert property ($fell(sync_n) |-> opens_s)
		else $error("frame not opened");
	AST_END: assert property ($rose(sync_n) |-> closes_s)
		else $error("frame not closed");
	AST_UPD_FRAME: assert property (dac_update |-> frame_active)
		else $error("latch outside a frame");
	AST_UPD_ONE: assert property (dac_update |=> !dac_update)
		else $error("latch pulse too long");
	AST_CODE: assert property ($changed(dac_code) |-> dac_update)
		else $error("code changed without latch");
	AST_EDGE: assert property ($changed(capture_rising) |-> frame_active)
		else $error("edge changed outside a frame");
	AST_OUT: assert property ($changed(serial_out) |-> frame_active)
		else $error("serial output moved while idle");
endmodule

// File: testbench/serial_dac_word_loader_tb_top.sv
`timescale 1ns/1ps
module serial_dac_word_loader_tb_top;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        sclk_pin, sync_n, serial_in, serial_out, dac_update, capture_rising, frame_active;
	logic [11:0] dac_code, code;
	logic [15:0] got, prev;
	logic        edge_r;
	int          bad_count = 0;
	int          checks = 0;
	int          pulses = 0;
	int          p0;
	logic [17:0] rows [8] = '{18'h21ABC, 18'h00555, 18'h03123, 18'h1C000,
		18'h31800, 18'h31FFF, 18'h0B000, 18'h21A5C};
	always #5 ref_clk = !ref_clk;
	always @(posedge ref_clk) if (dac_update === 1'b1) pulses <= pulses + 1;
	serial_dac_word_loader serial_dac_word_loader_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk_pin(sclk_pin),
		.sync_n(sync_n), .serial_in(serial_in), .serial_out(serial_out), .dac_code(dac_code),
		.dac_update(dac_update), .capture_rising(capture_rising), .frame_active(frame_active));
	spi_host_model spi_host_model_i (.ref_clk(ref_clk), .serial_out(serial_out), .sclk_pin(sclk_pin),
		.sync_n(sync_n), .serial_in(serial_in));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk("reset code", 16'h0000, {4'h0, dac_code});
		chk("reset edge", 16'h0000, {15'h0, capture_rising});
		chk("reset frame", 16'h0000, {14'h0, frame_active, serial_out});
		$display("test reset done");
		prev = 16'h0000;
		code = 12'h000;
		edge_r = 1'b0;
		foreach (rows[i]) begin
			p0 = pulses;
			spi_host_model_i.xfer(rows[i][15:0], 16, edge_r, got);
			if (rows[i][17]) code = rows[i][11:0];
			edge_r = rows[i][16];
			chk("chain out", prev, got);
			chk("dac code", {4'h0, code}, {4'h0, dac_code});
			chk("edge", {15'h0, edge_r}, {15'h0, capture_rising});
			chk("pulses", {15'h0, rows[i][17]}, 16'(pulses - p0));
			prev = rows[i][15:0];
			$display("test row %0d done", i);
		end
		// A short frame must not reach the latch.
		p0 = pulses;
		spi_host_model_i.xfer(16'h1333, 8, 1'b0, got);
		chk("short code", {4'h0, code}, {4'h0, dac_code});
		chk("short pulses", 16'h0000, 16'(pulses - p0));
		$display("test short frame done");
		spi_host_model_i.xfer(16'h2000, 16, 1'b0, got);
		spi_host_model_i.xfer(16'h0000, 16, 1'b0, got);
		chk("readback", {4'h0, code}, got);
		$display("test readback done");
		// A reset in mid-run must bring capture back to the falling edge.
		spi_host_model_i.xfer(16'hC000, 16, 1'b0, got);
		chk("rise set", 16'h0001, {15'h0, capture_rising});
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk("rerun edge", 16'h0000, {15'h0, capture_rising});
		chk("rerun code", 16'h0000, {4'h0, dac_code});
		spi_host_model_i.xfer(16'h1123, 16, 1'b0, got);
		chk("rerun load", 16'h0123, {4'h0, dac_code});
		chk("rerun chain", 16'h0000, got);
		$display("test reset rerun done");
		summarize();
	end
	initial begin
		#200000;
		bad_count++;
		summarize();
	end
endmodule
bind serial_dac_word_loader serial_dac_word_loader_checker serial_dac_word_loader_checker_i (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .sclk_pin(sclk_pin), .sync_n(sync_n), .serial_in(serial_in), .serial_out(serial_out),
	.dac_code(dac_code), .dac_update(dac_update), .capture_rising(capture_rising), .frame_active(frame_active));

// File: testbench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic ref_clk,
	input  wire logic serial_out,
	output logic      sclk_pin,
	output logic      sync_n,
	output logic      serial_in
);
	localparam realtime HALF = 62.5;
	initial begin
		sclk_pin = 1'b0;
		sync_n = 1'b1;
		serial_in = 1'b0;
	end
	// The shift clock stands still between frames; edges start 3 ns after a system edge.
	task automatic xfer(input logic [15:0] w, input int n, input logic rise, output logic [15:0] got);
		@(posedge ref_clk);
		#3;
		sclk_pin <= rise;
		#(4*HALF);
		sync_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			#HALF;
			serial_in <= w[15-i];
			sclk_pin <= !rise;
			#HALF;
			got = {got[14:0], serial_out};
			sclk_pin <= rise;
		end
		#(2*HALF);
		sync_n <= 1'b1;
		serial_in <= !serial_in;
		#(4*HALF);
	endtask
endmodule
